// >>> rtl/iouf_top.v
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "iouf_map.vh"
module iouf_top (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire [1:0] op_mode,
  input wire smp_stb,
  input wire [23:0] gyro_x,
  input wire [23:0] gyro_y,
  input wire [23:0] gyro_z,
  input wire [23:0] acc_x,
  input wire [23:0] acc_y,
  input wire [23:0] acc_z,
  input wire pps_pin,
  input wire tx_stb,
  input wire spec_req,
  output wire [7:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SEND = 2'h2;
  localparam integer GYRO_DLY = `IOUF_GYRO_DLY_US * `IOUF_INT_RATE / 1000000;
  localparam integer PPS_DLY = `IOUF_PPS_DLY_US * `IOUF_INT_RATE / 1000000;
  localparam [13:0] K_GYRO = (2.0 ** (`IOUF_ANGLE_FRAC - `IOUF_RATE_FRAC))
    * (2.0 ** `IOUF_KSHIFT) / `IOUF_INT_RATE;
  localparam [13:0] K_VEL = `IOUF_G0 * (2.0 ** (`IOUF_VEL_FRAC - `IOUF_ACC_FRAC))
    * (2.0 ** `IOUF_KSHIFT) / `IOUF_INT_RATE;
  localparam [13:0] K_GS = (2.0 ** (`IOUF_VEL_FRAC - `IOUF_ACC_FRAC))
    * (2.0 ** `IOUF_KSHIFT) / `IOUF_INT_RATE;

  function reg_hit;
    input [7:0] a;
    begin
      reg_hit = (a == `IOUF_REG_CTRL) | (a == `IOUF_REG_MODID) |
        (a == `IOUF_REG_SLOT) | (a == `IOUF_REG_STAT) | (a == `IOUF_REG_NCNT);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [8:0] ctrl_q;
  reg [7:0] modid_q;
  reg [15:0] slot_q;
  reg iclr_q;
  reg pps_s1_q;
  reg pps_s2_q;
  reg [1:0] state_q;
  reg [23:0] wait_q;
  reg [4:0] bi_q;
  reg spec_q;
  reg spec_pend_q;
  reg tx_pend_q;
  reg [15:0] cnt_q;
  reg [143:0] snap_q;
  reg pps_snap_q;
  reg [7:0] byte_d;
  wire [71:0] gyro_dly;
  wire pps_dly;
  wire [143:0] smp_all;
  wire [143:0] words;
  wire id_en;
  wire snap;
  wire start_spec;
  wire start_norm;
  wire buf_ready;
  wire push;
  wire [4:0] last;
  wire [4:0] dj;
  wire [15:0] den;
  wire acc;
  wire wr_fire;

  assign id_en = ctrl_q[`IOUF_CTRL_IDEN];
  assign acc = psel & penable;
  assign wr_fire = acc & pready_q & pwrite;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ctrl_q <= `IOUF_CTRL_RST;
      modid_q <= `IOUF_MODID_RST;
      slot_q <= `IOUF_SLOT_RST;
      iclr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~reg_hit(paddr);
      prdata_q <= 32'h00000000;
      iclr_q <= 1'b0;
      if (acc & ~pready_q & ~pwrite)
      begin
        case (paddr)
          `IOUF_REG_CTRL: prdata_q <= {24'h000000, ctrl_q[7:0]}
            | {23'h000000, ctrl_q[`IOUF_CTRL_MULTI], 8'h00};
          `IOUF_REG_MODID: prdata_q <= {24'h000000, modid_q};
          `IOUF_REG_SLOT: prdata_q <= {16'h0000, slot_q};
          `IOUF_REG_STAT: prdata_q <= {27'h0000000, out_valid, tx_pend_q,
            spec_pend_q, state_q == ST_WAIT, state_q != ST_IDLE};
          `IOUF_REG_NCNT: prdata_q <= {16'h0000, cnt_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
      if (wr_fire & (paddr == `IOUF_REG_CTRL))
      begin
        ctrl_q <= {1'b0, pwdata[7:0]} | {pwdata[`IOUF_CTRL_MULTI], 8'h00};
        iclr_q <= pwdata[`IOUF_CTRL_ICLR];
      end
      if (wr_fire & (paddr == `IOUF_REG_MODID) &
          ((op_mode == `IOUF_MODE_SERVICE) | (op_mode == `IOUF_MODE_UTILITY)))
        modid_q <= pwdata[7:0];
      if (wr_fire & (paddr == `IOUF_REG_SLOT))
        slot_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // delay alignment
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pps_s1_q <= 1'b0;
      pps_s2_q <= 1'b0;
    end
    else
    begin
      pps_s1_q <= pps_pin;
      pps_s2_q <= pps_s1_q;
    end
  end

  iouf_delay #(.W(72), .D(GYRO_DLY)) u_gdly (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .stb(smp_stb),
    .en(ctrl_q[`IOUF_CTRL_GDLY]),
    .din({gyro_z, gyro_y, gyro_x}),
    .dout(gyro_dly)
  );

  iouf_delay #(.W(1), .D(PPS_DLY)) u_pdly (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .stb(smp_stb),
    .en(ctrl_q[`IOUF_CTRL_PDLY]),
    .din(pps_s2_q),
    .dout(pps_dly)
  );

  assign smp_all = {acc_z, acc_y, acc_x, gyro_dly};
  // a zero count would divide by zero; the word then reads as zero
  assign den = (cnt_q == 16'h0000) ? 16'h0001 : cnt_q;

  // ----------------------------------------
  // per-axis accumulation, channels 0-2 gyro
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1)
    begin : ch
      wire signed [23:0] s = smp_all[c*24 +: 24];
      wire [1:0] unit = (c < 3) ? ctrl_q[`IOUF_CTRL_GU +: 2] : ctrl_q[`IOUF_CTRL_AU +: 2];
      wire [13:0] kinc = (c < 3) ? K_GYRO : K_VEL;
      wire [13:0] kint = (c < 3) ? K_GYRO :
        (ctrl_q[`IOUF_CTRL_AMS] ? K_VEL : K_GS);
      reg signed [39:0] sum_q;
      reg signed [39:0] int_q;
      reg [23:0] last_q;
      reg [23:0] word;
      wire signed [38:0] prod = s * $signed({1'b0, kint});
      wire signed [54:0] incp = sum_q * $signed({1'b0, kinc});
      wire signed [39:0] avg = sum_q / $signed({1'b0, den});

      always @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          sum_q <= 40'h0000000000;
          int_q <= 40'h0000000000;
          last_q <= 24'h000000;
        end
        else
        begin
          if (smp_stb)
            last_q <= s;
          // restart sum at snapshot, keep a coincident sample
          if (snap)
            sum_q <= smp_stb ? {{16{s[23]}}, s} : 40'h0000000000;
          else if (smp_stb)
            sum_q <= sum_q + {{16{s[23]}}, s};
          // one scaled term per internal sample
          if (iclr_q)
            int_q <= 40'h0000000000;
          else if (smp_stb)
            int_q <= int_q + {prod[38], prod};
        end
      end

      always @*
      begin
        case (unit)
          `IOUF_UNIT_PLAIN: word = last_q;
          `IOUF_UNIT_INC: word = incp[`IOUF_KSHIFT+23 -: 24];
          `IOUF_UNIT_AVG: word = avg[23:0];
          default: word = int_q[`IOUF_KSHIFT+23 -: 24];
        endcase
      end

      // channel 0 highest, bit 23 first
      assign words[(5-c)*24 +: 24] = word;
    end
  endgenerate

  // ----------------------------------------
  // datagram sequencing
  // ----------------------------------------
  assign start_spec = (state_q == ST_IDLE) & spec_pend_q;
  assign start_norm = (state_q == ST_IDLE) & ~spec_pend_q & tx_pend_q;
  assign snap = (start_norm & ~ctrl_q[`IOUF_CTRL_MULTI]) |
    ((state_q == ST_WAIT) & (wait_q == 24'h000000));
  // identifier adds one byte to either datagram
  assign last = spec_q ? {4'h0, id_en} : (5'h13 + {4'h0, id_en});
  assign dj = bi_q - 5'h01 - {4'h0, id_en};
  assign push = (state_q == ST_SEND) & buf_ready;

  always @*
  begin
    byte_d = 8'h00;
    if (bi_q == 5'h00)
      byte_d = spec_q ? `IOUF_DG_SPECIAL : `IOUF_DG_NORMAL;
    else if ((bi_q == 5'h01) & id_en)
      byte_d = modid_q;
    else if (dj < 5'h12)
      byte_d = snap_q[143 - 8*dj -: 8];
    else
      byte_d = {7'h00, pps_snap_q};
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      wait_q <= 24'h000000;
      bi_q <= 5'h00;
      spec_q <= 1'b0;
      spec_pend_q <= 1'b0;
      tx_pend_q <= 1'b0;
      cnt_q <= 16'h0000;
      snap_q <= 144'h0;
      pps_snap_q <= 1'b0;
    end
    else
    begin
      // new requests win over the take in the same cycle
      spec_pend_q <= spec_req | (spec_pend_q & ~start_spec);
      tx_pend_q <= tx_stb | (tx_pend_q & ~start_norm);
      if (snap)
      begin
        snap_q <= words;
        pps_snap_q <= pps_dly;
        cnt_q <= smp_stb ? 16'h0001 : 16'h0000;
      end
      else if (smp_stb & (cnt_q != 16'hFFFF))
        cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        ST_IDLE:
        begin
          bi_q <= 5'h00;
          if (start_spec)
          begin
            spec_q <= 1'b1;
            state_q <= ST_SEND;
          end
          else if (start_norm)
          begin
            spec_q <= 1'b0;
            if (ctrl_q[`IOUF_CTRL_MULTI])
            begin
              wait_q <= modid_q * slot_q;
              state_q <= ST_WAIT;
            end
            else
              state_q <= ST_SEND;
          end
        end
        ST_WAIT:
        begin
          if (wait_q == 24'h000000)
            state_q <= ST_SEND;
          else
            wait_q <= wait_q - 24'h000001;
        end
        ST_SEND:
        begin
          if (push & (bi_q == last))
            state_q <= ST_IDLE;
          else if (push)
            bi_q <= bi_q + 5'h01;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  // a receiver stall holds the sequencer rather than dropping bytes
  iouf_buf #(.W(8)) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(state_q == ST_SEND),
    .in_ready(buf_ready),
    .in_data(byte_d),
    .out_valid_q(out_valid),
    .out_ready(out_ready),
    .out_data_q(out_data)
  );
endmodule // iouf_top
`default_nettype wire

// >>> shared/iouf_map.vh
`ifndef IOUF_MAP_VH
`define IOUF_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IOUF_REG_CTRL 8'h00
`define IOUF_REG_MODID 8'h04
`define IOUF_REG_SLOT 8'h08
`define IOUF_REG_STAT 8'h0C
`define IOUF_REG_NCNT 8'h10
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define IOUF_CTRL_GU 0
`define IOUF_CTRL_AU 2
`define IOUF_CTRL_AMS 4
`define IOUF_CTRL_IDEN 5
`define IOUF_CTRL_GDLY 6
`define IOUF_CTRL_PDLY 7
`define IOUF_CTRL_MULTI 8
`define IOUF_CTRL_ICLR 9
`define IOUF_CTRL_RST 9'h000
`define IOUF_MODID_RST 8'h00
`define IOUF_SLOT_RST 16'h0100
// ----------------------------------------
// output units and operating modes
// ----------------------------------------
`define IOUF_UNIT_PLAIN 2'h0
`define IOUF_UNIT_INC 2'h1
`define IOUF_UNIT_AVG 2'h2
`define IOUF_UNIT_INT 2'h3
`define IOUF_MODE_NORMAL 2'h0
`define IOUF_MODE_SERVICE 2'h1
`define IOUF_MODE_UTILITY 2'h2
// ----------------------------------------
// datagram marks (values arbitrary)
// ----------------------------------------
`define IOUF_DG_NORMAL 8'hA5
`define IOUF_DG_SPECIAL 8'h5A
// ----------------------------------------
// scaling and timing
// ----------------------------------------
`define IOUF_INT_RATE 2000
`define IOUF_G0 9.80665
`define IOUF_RATE_FRAC 14
`define IOUF_ANGLE_FRAC 21
`define IOUF_ACC_FRAC 19
`define IOUF_VEL_FRAC 22
`define IOUF_KSHIFT 16
`define IOUF_GYRO_DLY_US 1000
`define IOUF_PPS_DLY_US 1500
`endif

// >>> rtl/iouf_delay.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// sample-tick delay line, depth of two or more
// ----------------------------------------
module iouf_delay #(
  parameter W = 1,
  parameter D = 2
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire stb,
  input wire en,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W*D-1:0] line_q;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      line_q <= {(W*D){1'b0}};
    else if (stb)
      line_q <= {line_q[W*(D-1)-1:0], din};
  end

  // bypass keeps the undelayed path free of latency
  assign dout = en ? line_q[W*D-1 -: W] : din;
endmodule // iouf_delay
`default_nettype wire

// >>> rtl/iouf_buf.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// two-entry buffer, head and valid from flops
// ----------------------------------------
module iouf_buf #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid_q,
  input wire out_ready,
  output reg [W-1:0] out_data_q
);
  reg [W-1:0] d1_q;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign push = in_valid & in_ready;
  assign pop = out_valid_q & out_ready;

  always @*
  begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop & ~push)
      cnt_d = cnt_q - 2'h1;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= 2'h0;
      out_valid_q <= 1'b0;
      out_data_q <= {W{1'b0}};
      d1_q <= {W{1'b0}};
    end
    else
    begin
      cnt_q <= cnt_d;
      out_valid_q <= (cnt_d != 2'h0);
      if (push & pop)
        out_data_q <= in_data;
      else if (push & (cnt_q == 2'h0))
        out_data_q <= in_data;
      else if (push)
        d1_q <= in_data;
      else if (pop)
        out_data_q <= d1_q;
    end
  end
endmodule // iouf_buf
`default_nettype wire

// >>> testbench/iouf_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ------
// port checker
// ------
module iouf_top_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic tx_stb,
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire take = psel && penable && !pready_q;
  apb_answer_a: assert property (take |=> pready_q)
    else $error("no ready after access");
  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  bad_addr_a: assert property (take && paddr > 8'h10 |=> pslverr_q && prdata_q == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (take && paddr <= 8'h10 && paddr[1:0] == 2'h0 |=> !pslverr_q)
    else $error("mapped access refused");
  idle_data_a: assert property (!pready_q |-> prdata_q == 32'h0 && !pslverr_q)
    else $error("bus outputs not idle");
  // stall must not lose or change a byte
  byte_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("byte changed under stall");
  lead_mark_a: assert property ($rose(out_valid) |-> out_data == 8'hA5 || out_data == 8'h5A)
    else $error("datagram lacks lead mark");
  tx_start_a: assert property (tx_stb && !out_valid |-> ##[1:100] out_valid)
    else $error("datagram did not start");
  cover property (tx_stb ##[1:100] out_valid);
  cover property (out_valid && !out_ready);
  cover property (pslverr_q);
endmodule // iouf_top_monitor
`default_nettype wire

// >>> testbench/iouf_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ------
// host side byte sink, optional half-rate stall
// ------
module iouf_sink (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic stall_en,
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  output logic out_ready
);
  logic [7:0] got [0:63];
  int cnt;
  logic tog_q;
  assign out_ready = !stall_en || tog_q;
  always @(posedge ref_clk)
  begin
    tog_q <= sys_rst ? 1'h0 : !tog_q;
    if (sys_rst)
      cnt <= 0;
    else if (out_valid && out_ready)
    begin
      got[cnt % 64] <= out_data;
      cnt <= cnt + 1;
    end
  end
endmodule // iouf_sink
`default_nettype wire

// >>> testbench/iouf_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module iouf_top_tb_top;
  logic ref_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_q, rd;
  logic pready_q, pslverr_q, er, smp_stb = 1'h0, pps_pin = 1'h0;
  logic tx_stb = 1'h0, spec_req = 1'h0, stall_en = 1'h0;
  logic [1:0] op_mode = 2'h0;
  logic [23:0] gyro_x = 24'h0, gyro_y = 24'h0, gyro_z = 24'h0;
  logic [23:0] acc_x = 24'h0, acc_y = 24'h0, acc_z = 24'h0;
  logic [39:0] isum;
  wire [7:0] out_data;
  wire out_valid, out_ready;
  int err_count = 0, checks_done = 0, base, lat;
  always #10 ref_clk = ~ref_clk;
  iouf_top u_iouf_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .op_mode(op_mode), .smp_stb(smp_stb), .gyro_x(gyro_x),
    .gyro_y(gyro_y), .gyro_z(gyro_z), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
    .pps_pin(pps_pin), .tx_stb(tx_stb), .spec_req(spec_req), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
  iouf_sink u_iouf_sink (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall_en(stall_en),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
  // ------
  // helpers
  // ------
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
      @(posedge ref_clk);
    while (pready_q !== 1'h1 && n++ < 50);
    // a slave that never answers counts as a mismatch
    if (pready_q !== 1'h1)
      chk(32'h1, {31'h0, pready_q});
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    chk(32'h0, {31'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(e, rd);
  endtask
  task automatic smp(input logic [23:0] g, input logic [23:0] a);
    @(posedge ref_clk);
    gyro_x <= g;
    gyro_y <= g + 24'h1;
    gyro_z <= g + 24'h2;
    acc_x <= a;
    acc_y <= a + 24'h1;
    acc_z <= a + 24'h2;
    smp_stb <= 1'h1;
    @(posedge ref_clk);
    smp_stb <= 1'h0;
  endtask
  // latency counts cycles from the request cycle to the first valid byte
  task automatic dg(input logic sp, input int n);
    int k;
    k = 0;
    lat = 1;
    base = u_iouf_sink.cnt;
    @(posedge ref_clk);
    if (sp)
      spec_req <= 1'h1;
    else
      tx_stb <= 1'h1;
    @(posedge ref_clk);
    tx_stb <= 1'h0;
    spec_req <= 1'h0;
    while (out_valid !== 1'h1 && lat < 300)
    begin
      @(posedge ref_clk);
      lat++;
    end
    while (u_iouf_sink.cnt < base + n && k++ < 300)
      @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk(n, u_iouf_sink.cnt - base);
  endtask
  function automatic logic [7:0] bt(input int i);
    return u_iouf_sink.got[(base + i) % 64];
  endfunction
  task automatic ck3(input int i, input logic [23:0] e);
    chk(e[23:16], bt(i));
    chk(e[15:8], bt(i + 1));
    chk(e[7:0], bt(i + 2));
  endtask
  // ------
  // scenarios
  // ------
  task automatic s_regs();
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h100);
    rdc(8'h0C, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk(32'h1, {31'h0, er});
    wr(8'h04, 32'h37);
    rdc(8'h04, 32'h0);
    op_mode <= 2'h1;
    wr(8'h04, 32'h37);
    rdc(8'h04, 32'h37);
  endtask
  task automatic s_plain();
    smp(24'h800001, 24'h123456);
    dg(1'h0, 20);
    chk(32'h4, lat);
    chk(8'hA5, bt(0));
    ck3(1, 24'h800001);
    ck3(4, 24'h800002);
    ck3(7, 24'h800003);
    ck3(10, 24'h123456);
    ck3(16, 24'h123458);
    chk(8'h0, bt(19));
  endtask
  // half-rate stall fills the two-entry buffer every other cycle
  task automatic s_id();
    wr(8'h00, 32'h20);
    stall_en <= 1'h1;
    smp(24'h000ABC, 24'h0);
    dg(1'h0, 21);
    chk(8'h37, bt(1));
    ck3(2, 24'h000ABC);
    dg(1'h1, 2);
    chk(8'h5A, bt(0));
    chk(8'h37, bt(1));
    stall_en <= 1'h0;
  endtask
  task automatic s_inc();
    wr(8'h00, 32'h05);
    smp(24'h0003E8, 24'h001000);
    smp(24'h0003E8, 24'h001000);
    dg(1'h0, 20);
    ck3(1, 24'h00007F);
    ck3(10, 24'h000141);
    dg(1'h0, 20);
    ck3(1, 24'h0);
    ck3(10, 24'h0);
  endtask
  task automatic s_avg();
    wr(8'h00, 32'h0A);
    smp(24'h00000A, 24'h000064);
    smp(24'h000014, 24'h0000C8);
    smp(24'h00001F, 24'h00012D);
    rdc(8'h10, 32'h3);
    dg(1'h0, 20);
    ck3(1, 24'h000014);
    ck3(10, 24'h0000C8);
  endtask
  task automatic s_int();
    wr(8'h00, 32'h21C);
    rdc(8'h00, 32'h1C);
    repeat (30) smp(24'h7FFFFF, 24'h7FFFFF);
    isum = 40'h1E * 40'h7FFFFF * 40'hA0B;
    dg(1'h0, 20);
    ck3(10, isum[39:16]);
    // gyro integrated, accel integrated in g*s
    wr(8'h00, 32'h20F);
    repeat (4) smp(24'h100, 24'h100);
    dg(1'h0, 20);
    ck3(1, 24'h41);
    ck3(10, 24'h4);
  endtask
  task automatic s_dly();
    wr(8'h00, 32'hC0);
    pps_pin <= 1'h1;
    smp(24'h1, 24'h0);
    smp(24'h2, 24'h0);
    smp(24'h3, 24'h0);
    dg(1'h0, 20);
    ck3(1, 24'h1);
    chk(8'h0, bt(19));
    wr(8'h00, 32'h0);
    // held words change only with a fresh sample
    smp(24'h3, 24'h0);
    dg(1'h0, 20);
    ck3(1, 24'h3);
    chk(8'h1, bt(19));
  endtask
  task automatic s_multi();
    wr(8'h08, 32'h10);
    op_mode <= 2'h2;
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h120);
    dg(1'h0, 21);
    chk(32'h35, lat);
    chk(8'h3, bt(1));
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'h0;
    s_regs();
    s_plain();
    s_id();
    s_inc();
    s_avg();
    s_int();
    s_dly();
    s_multi();
    conclude();
  end
  initial
  begin
    #400000;
    err_count++;
    conclude();
  end
endmodule // iouf_top_tb_top
bind iouf_top iouf_top_monitor u_iouf_top_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .tx_stb(tx_stb), .out_data(out_data), .out_valid(out_valid),
  .out_ready(out_ready));
`default_nettype wire
